// [dpl_consts.svh]
// Register offsets, field positions, reset values and timing counts of the port pin block.
`ifndef DPL_CONSTS_SVH
`define DPL_CONSTS_SVH

`define DPL_ADDR_CTRL 12'h000
`define DPL_ADDR_PWR 12'h004
`define DPL_ADDR_GRN 12'h008
`define DPL_ADDR_AMB 12'h00c
`define DPL_ADDR_STAT 12'h010
`define DPL_ADDR_PINS 12'h014

`define DPL_CTRL_CFG_EXT 0
`define DPL_CTRL_LED_EN 1

`define DPL_STAT_DONE 0
`define DPL_STAT_POL 1
`define DPL_STAT_DIS_LSB 2
`define DPL_STAT_NREM_LSB 4
`define DPL_STAT_ENA_LSB 7
`define DPL_STAT_FIX_LSB 15

`define DPL_PINS_POL 0

`define DPL_CTRL_RST 1'b0
`define DPL_PWR_RST 7'h00
`define DPL_GRN_RST 7'h00
`define DPL_AMB_RST 3'h0

`define DPL_STRAP_OFF 2'b00
`define DPL_STRAP_ONE 2'b01
`define DPL_STRAP_TWO 2'b10
`define DPL_STRAP_THREE 2'b11

`define DPL_SETTLE_CYC 2'd2

`endif

// [dpl_pkg.sv]
// Types shared by the port pin block modules.
package dpl_pkg;

  typedef enum logic [1:0] {
    DPL_CAP_SETTLE = 2'b01,
    DPL_CAP_DONE = 2'b10
  } dpl_cap_state_t;

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
  } dpl_sync_st_t;

  typedef struct packed {
    dpl_cap_state_t state;
    logic [1:0] cnt;
    logic done;
    logic pol;
    logic [1:0] dis;
    logic [1:0] nrem;
  } dpl_cap_st_t;

  typedef struct packed {
    logic cfg_ext;
    logic led_en;
    logic [7:1] pwr_req;
    logic [7:1] grn_req;
    logic [7:5] amb_req;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [7:1] pwr_out;
    logic [7:1] pwr_oe;
    logic [7:1] grn_out;
    logic [7:1] grn_oe;
    logic [7:5] amb_out;
    logic [7:5] amb_oe;
  } dpl_main_st_t;

endpackage

// [dpl_strap_if.sv]
// Carrier for the captured strap values between the capture stage and the pin logic.
`timescale 1ns/1ns
interface dpl_strap_if;
  logic done;
  logic pol;
  logic [1:0] dis;
  logic [1:0] nrem;
  logic [7:0] live;

  modport cap (output done, output pol, output dis, output nrem, output live);
  modport use_side (input done, input pol, input dis, input nrem, input live);
endinterface

// [dpl_sync.sv]
// Two-stage synchroniser for the strap and LED pin inputs.
`timescale 1ns/1ns
module dpl_sync
  import dpl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_sync
);
  dpl_sync_st_t q;
  dpl_sync_st_t d;

  always_comb begin
    d = q;
    if (ce) begin
      d.s1 = pin_in;
      d.s2 = q.s1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pin_sync = q.s2;
endmodule

// [dpl_strap_cap.sv]
// Captures the straps once the synchroniser has settled after reset release.
`timescale 1ns/1ns
`include "dpl_consts.svh"
module dpl_strap_cap
  import dpl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [7:0] pin_sync,
  dpl_strap_if.cap strap
);
  dpl_cap_st_t q;
  dpl_cap_st_t d;

  always_comb begin
    d = q;
    if (ce) begin
      unique case (q.state)
        DPL_CAP_SETTLE: begin
          if (q.cnt == `DPL_SETTLE_CYC) begin
            d.state = DPL_CAP_DONE;
            d.done = 1'b1;
            d.pol = pin_sync[0];
            d.dis = pin_sync[4:3];
            d.nrem = pin_sync[2:1];
          end else begin
            d.cnt = q.cnt + 2'd1;
          end
        end
        DPL_CAP_DONE: begin
          d.state = DPL_CAP_DONE;
        end
        default: begin
          d.state = DPL_CAP_SETTLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{state: DPL_CAP_SETTLE, default: '0};
    end else begin
      q <= d;
    end
  end

  assign strap.done = q.done;
  assign strap.pol = q.pol;
  assign strap.dis = q.dis;
  assign strap.nrem = q.nrem;
  assign strap.live = pin_sync;
endmodule

// [dpl_top.sv]
// Downstream port power enables, indicator LEDs and strap capture with an APB register file.
//
// Operation
// - Seven port power outputs whose active level follows the polarity strap.
// - Polarity strap captured at reset release; one means high, zero means low.
// - Green LEDs of ports seven to five are always active low.
// - Amber LEDs of ports seven to five are always active low.
// - With external config and LEDs enabled, green four and three are active low.
// - With external config and LEDs enabled, green two and one are active low.
// - Internal config samples two port-disable straps at reset release.
// - Disable code 00 none, 01 port 7, 10 ports 7-6, 11 ports 7-5.
// - Green four polarity from disable bit one, green three from bit zero.
// - Internal config samples two fixed-device straps at reset release.
// - Fixed code 00 none, 01 port 1, 10 ports 1-2, 11 ports 1-3.
// - Green two polarity from fixed bit one, green one from bit zero.
`timescale 1ns/1ns
`include "dpl_consts.svh"
module dpl_top
  import dpl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_enable_polarity_strap,
  output logic [7:1] port_power_enable,
  output logic [7:1] port_power_enable_oe,
  input wire logic [7:1] green_port_led_in,
  output logic [7:1] green_port_led_out,
  output logic [7:1] green_port_led_oe,
  output logic [7:5] amber_port_led_out,
  output logic [7:5] amber_port_led_oe
);
  import dpl_pkg::*;

  dpl_strap_if strap ();
  logic [7:0] pin_sync;
  dpl_main_st_t q;
  dpl_main_st_t d;

  // The polarity strap sits on bit zero; the green pins follow at their port numbers.
  dpl_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .pin_in({green_port_led_in, power_enable_polarity_strap}),
    .pin_sync(pin_sync)
  );

  dpl_strap_cap u_cap (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .pin_sync(pin_sync),
    .strap(strap.cap)
  );

  always_comb begin
    logic [7:1] ena;
    logic [7:1] fix;
    logic [7:1] led_low;
    logic [7:1] act;
    logic [31:0] rd;
    logic err;
    ena = 7'h7f;
    fix = 7'h00;
    led_low = 7'h7f;
    act = 7'h00;
    rd = 32'h0000_0000;
    err = 1'b0;
    d = q;

    // Strap decode applies only while the internal default configuration is in use.
    if (!q.cfg_ext) begin
      unique case (strap.dis)
        `DPL_STRAP_OFF: ena = 7'h7f;
        `DPL_STRAP_ONE: ena = 7'h3f;
        `DPL_STRAP_TWO: ena = 7'h1f;
        `DPL_STRAP_THREE: ena = 7'h0f;
      endcase
      unique case (strap.nrem)
        `DPL_STRAP_OFF: fix = 7'h00;
        `DPL_STRAP_ONE: fix = 7'h01;
        `DPL_STRAP_TWO: fix = 7'h03;
        `DPL_STRAP_THREE: fix = 7'h07;
      endcase
      led_low[4] = strap.dis[1];
      led_low[3] = strap.dis[0];
      led_low[2] = strap.nrem[1];
      led_low[1] = strap.nrem[0];
    end

    // Register read data is prepared in the setup phase and stands through the access phase.
    if (psel && !penable) begin
      unique case (paddr)
        `DPL_ADDR_CTRL: begin
          rd[`DPL_CTRL_CFG_EXT] = q.cfg_ext;
          rd[`DPL_CTRL_LED_EN] = q.led_en;
        end
        `DPL_ADDR_PWR: rd[7:1] = q.pwr_req;
        `DPL_ADDR_GRN: rd[7:1] = q.grn_req;
        `DPL_ADDR_AMB: rd[7:5] = q.amb_req;
        `DPL_ADDR_STAT: begin
          rd[`DPL_STAT_DONE] = strap.done;
          rd[`DPL_STAT_POL] = strap.pol;
          rd[`DPL_STAT_DIS_LSB +: 2] = strap.dis;
          rd[`DPL_STAT_NREM_LSB +: 2] = strap.nrem;
          rd[`DPL_STAT_ENA_LSB +: 7] = ena;
          rd[`DPL_STAT_FIX_LSB +: 7] = fix;
        end
        `DPL_ADDR_PINS: rd[7:0] = strap.live;
        default: err = 1'b1;
      endcase
      d.pready = 1'b1;
      d.prdata = rd;
      d.pslverr = err;
    end else begin
      d.pready = 1'b0;
      d.pslverr = 1'b0;
      d.prdata = 32'h0000_0000;
    end

    // A write lands at the edge that completes the access phase.
    if (psel && penable && q.pready && pwrite && !q.pslverr) begin
      unique case (paddr)
        `DPL_ADDR_CTRL: begin
          d.cfg_ext = pwdata[`DPL_CTRL_CFG_EXT];
          d.led_en = pwdata[`DPL_CTRL_LED_EN];
        end
        `DPL_ADDR_PWR: d.pwr_req = pwdata[7:1];
        `DPL_ADDR_GRN: d.grn_req = pwdata[7:1];
        `DPL_ADDR_AMB: d.amb_req = pwdata[7:5];
        default: d.pslverr = 1'b0;
      endcase
    end

    // A disabled port never gets power, and its indicators stay dark.
    act = q.pwr_req & ena;
    for (int p = 1; p <= 7; p++) begin
      d.pwr_oe[p] = strap.done;
      d.pwr_out[p] = strap.pol ? act[p] : !act[p];
      if (p >= 5) begin
        d.grn_oe[p] = strap.done;
        d.grn_out[p] = !(q.grn_req[p] && ena[p]);
        d.amb_oe[p] = strap.done;
        d.amb_out[p] = !(q.amb_req[p] && ena[p]);
      end else if (q.cfg_ext) begin
        d.grn_oe[p] = strap.done && q.led_en;
        d.grn_out[p] = !q.grn_req[p];
      end else begin
        d.grn_oe[p] = strap.done;
        d.grn_out[p] = led_low[p] ? !q.grn_req[p] : q.grn_req[p];
      end
    end

    if (!ce) begin
      d = q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{cfg_ext: `DPL_CTRL_RST, led_en: `DPL_CTRL_RST, pwr_req: `DPL_PWR_RST,
             grn_req: `DPL_GRN_RST, amb_req: `DPL_AMB_RST, default: '0};
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign port_power_enable = q.pwr_out;
  assign port_power_enable_oe = q.pwr_oe;
  assign green_port_led_out = q.grn_out;
  assign green_port_led_oe = q.grn_oe;
  assign amber_port_led_out = q.amb_out;
  assign amber_port_led_oe = q.amb_oe;
endmodule

// [dpl_pins_model.sv]
// Board model of the strap resistors and LED pin wiring.
`timescale 1ns/1ns
module dpl_pins_model (
  input logic [1:0] dis,
  input logic [1:0] nrem,
  input logic [7:1] oe,
  input logic [7:1] out,
  output logic [7:1] pin
);
  // Resistors hold the strap levels; an enabled driver overrides them.
  assign pin = (oe & out) | (~oe & {3'h7, dis, nrem});
endmodule

// [dpl_properties.sv]
// Concurrent checks on the bus answer and pin outputs of the port pin block.
`timescale 1ns/1ns
module dpl_chk (
  input logic pclk,
  input logic presetn,
  input logic ce,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic [7:1] port_power_enable,
  input logic [7:1] green_port_led_out,
  input logic [7:1] green_port_led_oe,
  input logic [7:5] amber_port_led_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn || !ce);
  sequence setup_s; psel && !penable; endsequence
  sequence wr_s(a); psel && penable && pready && pwrite && paddr == a; endsequence
  sequence hold_s; (green_port_led_oe == 7'h00) [*3]; endsequence
  ready_pulse_a: assert property (setup_s |=> pready ##1 !pready)
    else $error("ready not a single pulse");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  idle_data_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  unmapped_err_a: assert property (setup_s ##0 paddr > 12'h014 |=> pslverr)
    else $error("unmapped access not refused");
  power_off_a: assert property (
    wr_s(12'h004) ##0 pwdata[7:1] == 7'h00 |-> ##2
    (port_power_enable == 7'h00 || port_power_enable == 7'h7f))
    else $error("power enables not at one idle level");
  green_off_a: assert property (wr_s(12'h008) ##0 !pwdata[7] |-> ##2 green_port_led_out[7])
    else $error("green seven off not high");
  amber_off_a: assert property (wr_s(12'h00c) ##0 !pwdata[5] |-> ##2 amber_port_led_out[5])
    else $error("amber five off not high");
  oe_release_a: assert property (
    $rose(presetn) |-> hold_s ##[1:3] green_port_led_oe[7:5] == 3'h7)
    else $error("pin drive timing after release");
  oe_hold_a: assert property (green_port_led_oe[7] |=> green_port_led_oe[7])
    else $error("pin drive dropped");
endmodule
bind dpl_top dpl_chk u_dpl_chk (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .port_power_enable, .green_port_led_out, .green_port_led_oe,
  .amber_port_led_out);

// [tb.sv]
// Self-checking bench for the port pin block with random requests.
`timescale 1ns/1ns
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pol = 0, pready, pslverr, er;
  logic ce = 1;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [1:0] dis = 0, nrem = 0;
  logic [7:1] pwr, poe, goe, gout, gpin, req, ena;
  logic [7:5] aout, aoe;
  logic [15:0] seed = 16'h9eae;
  logic [11:0] ad [3] = '{12'h004, 12'h008, 12'h00c};
  int num_errors = 0, samples_checked = 0, cycles = 0;
  always #4 pclk = ~pclk;
  dpl_top u_dpl_top (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .power_enable_polarity_strap(pol), .port_power_enable(pwr),
    .port_power_enable_oe(poe), .green_port_led_in(gpin), .green_port_led_out(gout),
    .green_port_led_oe(goe), .amber_port_led_out(aout), .amber_port_led_oe(aoe));
  dpl_pins_model u_dpl_pins_model (.dis, .nrem, .oe(goe), .out(gout), .pin(gpin));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic close_out;
    if (num_errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      close_out;
    end
  end
  initial begin
    for (int k = 0; k < 5; k++) begin
      @(posedge pclk);
      presetn <= 1'b0;
      dis <= k[1:0];
      nrem <= ~k[1:0];
      pol <= k[0];
      repeat (20) @(posedge pclk);
      chk({poe, aoe, goe}, 0);
      presetn <= 1'b1;
      // On odd passes the clock enable stays low, so capture must wait for enabled edges.
      ce <= !k[0];
      repeat (5) @(posedge pclk);
      if (k[0]) chk({poe, aoe, goe}, 0);
      ce <= 1'b1;
      repeat (6) @(posedge pclk);
      apb(1'b0, 12'h010, 0);
      chk(rd, {10'h0, (7'h1 << nrem) - 7'h1, 1'b0, 7'h7f >> dis, 1'b0, nrem, dis, pol, 1'b1});
      apb(1'b0, 12'h018, 0);
      chk({er, rd[30:0]}, 32'h80000000);
      if (k == 4) apb(1'b1, 12'h000, 3);
      ena = k == 4 ? 7'h7f : 7'h7f >> dis;
      for (int j = 0; j < 3; j++) begin
        seed = lfsr(seed);
        req = j == 0 ? 7'h7f : j == 1 ? 7'h00 : seed[7:1];
        foreach (ad[i]) apb(1'b1, ad[i], {24'h0, req, 1'b0});
        @(posedge pclk);
        chk({poe, aoe, goe}, 17'h1ffff);
        chk(pwr, (req & ena) ^ {7{~pol}});
        chk(gout, (req & ena) ^ (k == 4 ? 7'h7f : {3'h7, dis, nrem}));
        chk(aout, (req[7:5] & ena[7:5]) ^ 3'h7);
        apb(1'b0, 12'h008, 0);
        chk(rd, {24'h0, req, 1'b0});
      end
    end
    close_out;
  end
endmodule
